/* File: hw/pbm_pkg.sv */
package pbm_pkg;

  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int PBM_LINES          = 16;
  localparam int PBM_FIELDS_PER_REG = 8;
  localparam int PBM_CAPCOMP        = 6;

  // ------------------------------------------------------------
  // register indices, byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [31:0] PBM_IDX_DATA   = 32'h05ffffc2;
  localparam logic [31:0] PBM_IDX_DIR    = 32'h05ffffc6;
  localparam logic [31:0] PBM_IDX_UPPER  = 32'h05ffffcc;
  localparam logic [31:0] PBM_IDX_LOWER  = 32'h05ffffce;
  localparam logic [31:0] PBM_IDX_STROBE = 32'h05ffffee;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] PBM_RST_DATA   = 16'h0000;
  localparam logic [15:0] PBM_RST_DIR    = 16'h0000;
  localparam logic [15:0] PBM_RST_FSEL   = 16'h0000;
  localparam logic [15:0] PBM_RST_STROBE = 16'h5fff;

  // ------------------------------------------------------------
  // field layout and codes
  // ------------------------------------------------------------
  localparam int          PBM_STB_HI_LSB = 14;
  localparam int          PBM_STB_LO_LSB = 12;
  localparam logic [15:0] PBM_STB_WMASK  = 16'hf000;

  localparam logic [1:0] PBM_SEL_GPIO = 2'h0;
  localparam logic [1:0] PBM_SEL_ALT1 = 2'h1;
  localparam logic [1:0] PBM_SEL_ALT2 = 2'h2;
  localparam logic [1:0] PBM_SEL_PAT  = 2'h3;

  localparam logic [1:0] PBM_STB_CS  = 2'h1;
  localparam logic [1:0] PBM_STB_CAS = 2'h2;

  // byte address of a register index
  function automatic logic [31:0] pbm_addr(input logic [31:0] idx);
    pbm_addr = {idx[29:0], 2'b00};
  endfunction : pbm_addr

endpackage : pbm_pkg

/* File: hw/pbm_line_if.sv */
interface pbm_line_if;
  logic [1:0] code;
  logic       gpio_dat;
  logic       gpio_dir;
  logic       pat;
  logic       f1_out;
  logic       f1_oe;
  logic       f2_out;
  logic       f2_oe;
  logic       pin_in;
  logic       pin_out;
  logic       pin_oe;
  logic       f1_in;
  logic       f2_in;

  modport mux (
    input  code, gpio_dat, gpio_dir, pat, f1_out, f1_oe, f2_out, f2_oe, pin_in,
    output pin_out, pin_oe, f1_in, f2_in
  );
  modport ctl (
    output code, gpio_dat, gpio_dir, pat, f1_out, f1_oe, f2_out, f2_oe, pin_in,
    input  pin_out, pin_oe, f1_in, f2_in
  );
endinterface : pbm_line_if

/* File: hw/pbm_line_mux.sv */
module pbm_line_mux (
  input  wire logic i_sys_clk,
  input  wire logic i_reset,
  pbm_line_if.mux   line
);
  import pbm_pkg::*;

  // ------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      line.pin_out <= 1'b0;
      line.pin_oe  <= 1'b0;
    end else begin
      case (line.code)
        PBM_SEL_GPIO: begin
          line.pin_out <= line.gpio_dat;
          line.pin_oe  <= line.gpio_dir;
        end
        PBM_SEL_ALT1: begin
          line.pin_out <= line.f1_out;
          line.pin_oe  <= line.f1_oe;
        end
        PBM_SEL_ALT2: begin
          line.pin_out <= line.f2_out;
          line.pin_oe  <= line.f2_oe;
        end
        PBM_SEL_PAT: begin
          line.pin_out <= line.pat;
          line.pin_oe  <= 1'b1;
        end
        default: begin
          line.pin_out <= 1'b0;
          line.pin_oe  <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // pin level to peripherals
  // ------------------------------------------------------------
  // route only when selected
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      line.f1_in <= 1'b0;
      line.f2_in <= 1'b0;
    end else begin
      line.f1_in <= (line.code == PBM_SEL_ALT1) ? line.pin_in : 1'b0;
      line.f2_in <= (line.code == PBM_SEL_ALT2) ? line.pin_in : 1'b0;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_gpio_dir;
    @(posedge i_sys_clk) disable iff (i_reset)
    (line.code == PBM_SEL_GPIO) |=> (line.pin_oe == $past(line.gpio_dir));
  endproperty
  a_gpio_dir: assert property (p_gpio_dir) else $error("gpio enable not following direction");

  property p_alt_in_gated;
    @(posedge i_sys_clk) disable iff (i_reset)
    (line.code != PBM_SEL_ALT1) |=> !line.f1_in;
  endproperty
  a_alt_in_gated: assert property (p_alt_in_gated) else $error("unselected input leaks pin level");

endmodule : pbm_line_mux

/* File: hw/pbm_pin_mux.sv */
// Decided for this implementation: the APB slave port.
module pbm_pin_mux (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [31:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic [15:0] i_pb_pin,
  output logic      [15:0] o_pb_pin,
  output logic      [15:0] o_pb_oe,
  input  wire logic [15:0] i_pattern_output,
  output logic             o_interrupt_input_seven,
  output logic             o_interrupt_input_six,
  output logic             o_interrupt_input_five,
  output logic             o_interrupt_input_four,
  input  wire logic        i_serial_ch1_clock_out,
  input  wire logic        i_serial_ch1_clock_oe,
  output logic             o_serial_ch1_clock_in,
  input  wire logic        i_serial_ch0_clock_out,
  input  wire logic        i_serial_ch0_clock_oe,
  output logic             o_serial_ch0_clock_in,
  input  wire logic        i_serial_ch1_transmit,
  input  wire logic        i_serial_ch0_transmit,
  output logic             o_serial_ch1_receive,
  output logic             o_serial_ch0_receive,
  output logic             o_timer_clock_input_d,
  output logic             o_timer_clock_input_c,
  input  wire logic        i_timer4_compare_out_b,
  input  wire logic        i_timer4_compare_out_a,
  input  wire logic [5:0]  i_timer_capcomp_out,
  input  wire logic [5:0]  i_timer_capcomp_oe,
  output logic      [5:0]  o_timer_capcomp_in,
  input  wire logic        i_chip_select_one,
  input  wire logic        i_chip_select_three,
  input  wire logic        i_column_strobe_high,
  input  wire logic        i_column_strobe_low,
  output logic             o_strobe_high_pin,
  output logic             o_strobe_high_oe,
  output logic             o_strobe_low_pin,
  output logic             o_strobe_low_oe
);
  import pbm_pkg::*;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [1:0] line_code(input logic [15:0] upper, input logic [15:0] lower, input int line);
    logic [15:0] src;
    int          pos;
    src = (line >= PBM_FIELDS_PER_REG) ? upper : lower;
    pos = (line % PBM_FIELDS_PER_REG) * 2;
    line_code = src[pos +: 2];
  endfunction : line_code

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wdata,
                                        input logic [3:0] strb, input logic [15:0] wmask);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    merge = (old & ~lanes) | (wdata[15:0] & lanes);
  endfunction : merge

  // {pin, enable} of a strobe pin; reserved codes leave it undriven
  function automatic logic [1:0] strobe_drive(input logic [1:0] code, input logic cs, input logic cas);
    case (code)
      PBM_STB_CS:  strobe_drive = {cs, 1'b1};
      PBM_STB_CAS: strobe_drive = {cas, 1'b1};
      default:     strobe_drive = 2'b00;
    endcase
  endfunction : strobe_drive

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [15:0] data_r;
  logic [15:0] dir_r;
  logic [15:0] upper_r;
  logic [15:0] lower_r;
  logic [15:0] strobe_r;
  logic [15:0] pat_mask;
  logic [15:0] pin_view;
  logic [1:0]  code_v [PBM_LINES];
  logic        wr_en;
  logic        setup;
  logic        hit;
  logic [15:0] rd_val;

  assign o_pready = 1'b1;
  assign setup    = i_psel & ~i_penable;
  assign wr_en    = i_psel & i_penable & i_pwrite;

  always_comb begin
    for (int k = 0; k < PBM_LINES; k++) begin
      code_v[k]   = line_code(upper_r, lower_r, k);
      pat_mask[k] = (code_v[k] == PBM_SEL_PAT);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      upper_r <= PBM_RST_FSEL;
      lower_r <= PBM_RST_FSEL;
    end else if (wr_en) begin
      if (i_paddr == pbm_addr(PBM_IDX_UPPER)) begin
        upper_r <= merge(upper_r, i_pwdata, i_pstrb, 16'hffff);
      end
      if (i_paddr == pbm_addr(PBM_IDX_LOWER)) begin
        lower_r <= merge(lower_r, i_pwdata, i_pstrb, 16'hffff);
      end
    end
  end

  // low bits reserved, read as one
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      strobe_r <= PBM_RST_STROBE;
    end else if (wr_en && i_paddr == pbm_addr(PBM_IDX_STROBE)) begin
      strobe_r <= merge(strobe_r, i_pwdata, i_pstrb, PBM_STB_WMASK);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      dir_r <= PBM_RST_DIR;
    end else if (wr_en && i_paddr == pbm_addr(PBM_IDX_DIR)) begin
      dir_r <= merge(dir_r, i_pwdata, i_pstrb, 16'hffff);
    end
  end

  // data bits of pattern lines are locked against writes
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      data_r <= PBM_RST_DATA;
    end else if (wr_en && i_paddr == pbm_addr(PBM_IDX_DATA)) begin
      data_r <= merge(data_r, i_pwdata, i_pstrb, ~pat_mask);
    end
  end

  // ------------------------------------------------------------
  // apb read and error, latched in setup
  // ------------------------------------------------------------
  // inputs read the pin, outputs read back the latch
  assign pin_view = (dir_r & data_r) | (~dir_r & i_pb_pin);

  always_comb begin
    hit    = 1'b1;
    rd_val = 16'h0000;
    case (i_paddr)
      pbm_addr(PBM_IDX_DATA):   rd_val = pin_view;
      pbm_addr(PBM_IDX_DIR):    rd_val = dir_r;
      pbm_addr(PBM_IDX_UPPER):  rd_val = upper_r;
      pbm_addr(PBM_IDX_LOWER):  rd_val = lower_r;
      pbm_addr(PBM_IDX_STROBE): rd_val = strobe_r;
      default:                  hit    = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_prdata  <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else if (setup) begin
      o_prdata  <= {16'h0000, rd_val};
      o_pslverr <= ~hit;
    end
  end

  // ------------------------------------------------------------
  // port b lines
  // ------------------------------------------------------------
  logic [15:0] f2_out_v;
  logic [15:0] f2_oe_v;
  logic [15:0] f1_in_v;
  logic [15:0] f2_in_v;

  assign f2_out_v = {2'b00, i_serial_ch1_clock_out, i_serial_ch0_clock_out,
                     i_serial_ch1_transmit, 1'b0, i_serial_ch0_transmit, 1'b0,
                     i_timer4_compare_out_b, i_timer4_compare_out_a, i_timer_capcomp_out};
  assign f2_oe_v  = {2'b00, i_serial_ch1_clock_oe, i_serial_ch0_clock_oe,
                     4'b1010, 2'b11, i_timer_capcomp_oe};

  pbm_line_if u_line [PBM_LINES] ();

  for (genvar g = 0; g < PBM_LINES; g++) begin : g_line
    assign u_line[g].code     = code_v[g];
    assign u_line[g].gpio_dat = data_r[g];
    assign u_line[g].gpio_dir = dir_r[g];
    assign u_line[g].pat      = i_pattern_output[g];
    // first functions are inputs or reserved
    assign u_line[g].f1_out   = 1'b0;
    assign u_line[g].f1_oe    = 1'b0;
    assign u_line[g].f2_out   = f2_out_v[g];
    assign u_line[g].f2_oe    = f2_oe_v[g];
    assign u_line[g].pin_in   = i_pb_pin[g];
    assign o_pb_pin[g]        = u_line[g].pin_out;
    assign o_pb_oe[g]         = u_line[g].pin_oe;
    assign f1_in_v[g]         = u_line[g].f1_in;
    assign f2_in_v[g]         = u_line[g].f2_in;

    pbm_line_mux u_mux (
      .i_sys_clk (i_sys_clk),
      .i_reset   (i_reset),
      .line      (u_line[g])
    );
  end

  assign o_interrupt_input_seven = f1_in_v[15];
  assign o_interrupt_input_six   = f1_in_v[14];
  assign o_interrupt_input_five  = f1_in_v[13];
  assign o_interrupt_input_four  = f1_in_v[12];
  assign o_serial_ch1_clock_in   = f2_in_v[13];
  assign o_serial_ch0_clock_in   = f2_in_v[12];
  assign o_serial_ch1_receive    = f2_in_v[10];
  assign o_serial_ch0_receive    = f2_in_v[8];
  assign o_timer_clock_input_d   = f1_in_v[7];
  assign o_timer_clock_input_c   = f1_in_v[6];
  assign o_timer_capcomp_in      = f2_in_v[5:0];

  // ------------------------------------------------------------
  // strobe pins
  // ------------------------------------------------------------
  logic [1:0] hi_code;
  logic [1:0] lo_code;
  assign hi_code = strobe_r[PBM_STB_HI_LSB +: 2];
  assign lo_code = strobe_r[PBM_STB_LO_LSB +: 2];

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      {o_strobe_high_pin, o_strobe_high_oe} <= 2'b00;
      {o_strobe_low_pin, o_strobe_low_oe}   <= 2'b00;
    end else begin
      {o_strobe_high_pin, o_strobe_high_oe} <= strobe_drive(hi_code, i_chip_select_one, i_column_strobe_high);
      {o_strobe_low_pin, o_strobe_low_oe}   <= strobe_drive(lo_code, i_chip_select_three, i_column_strobe_low);
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_fsel_reset;
    @(posedge i_sys_clk) disable iff (i_reset)
    $past(i_reset) |-> (upper_r == 16'h0000 && lower_r == 16'h0000 && o_pb_oe == 16'h0000);
  endproperty
  a_fsel_reset: assert property (p_fsel_reset) else $error("selection not gpio after reset");
  property p_line15_pat;
    @(posedge i_sys_clk) disable iff (i_reset)
    (code_v[15] == PBM_SEL_PAT) |=> (o_pb_oe[15] && o_pb_pin[15] == $past(i_pattern_output[15]));
  endproperty
  a_line15_pat: assert property (p_line15_pat) else $error("line 15 not carrying pattern");
  property p_irq_input;
    @(posedge i_sys_clk) disable iff (i_reset)
    (code_v[15] == PBM_SEL_ALT1) |=> (!o_pb_oe[15] && o_interrupt_input_seven == $past(i_pb_pin[15]));
  endproperty
  a_irq_input: assert property (p_irq_input) else $error("interrupt input not routed");
  property p_reserved_line;
    @(posedge i_sys_clk) disable iff (i_reset)
    (code_v[14] == PBM_SEL_ALT2) |=> !o_pb_oe[14];
  endproperty
  a_reserved_line: assert property (p_reserved_line) else $error("reserved code drives pin");
  property p_serial_ch1_transmit;
    @(posedge i_sys_clk) disable iff (i_reset)
    (code_v[11] == PBM_SEL_ALT2) |=> (o_pb_oe[11] && o_pb_pin[11] == $past(i_serial_ch1_transmit));
  endproperty
  a_serial_ch1_transmit: assert property (p_serial_ch1_transmit) else $error("transmit ch1 not on line 11");
  property p_cas_high;
    @(posedge i_sys_clk) disable iff (i_reset)
    (hi_code == PBM_STB_CAS) |=> (o_strobe_high_oe && o_strobe_high_pin == $past(i_column_strobe_high));
  endproperty
  a_cas_high: assert property (p_cas_high) else $error("high strobe not column strobe");
  property p_low_reserved;
    @(posedge i_sys_clk) disable iff (i_reset)
    (lo_code == 2'h0 || lo_code == 2'h3) |=> !o_strobe_low_oe;
  endproperty
  a_low_reserved: assert property (p_low_reserved) else $error("reserved low strobe code drives");
  property p_upper_write;
    @(posedge i_sys_clk) disable iff (i_reset)
    (wr_en && i_paddr == pbm_addr(PBM_IDX_UPPER) && i_pstrb[1:0] == 2'b11) |=> (upper_r == $past(i_pwdata[15:0]));
  endproperty
  a_upper_write: assert property (p_upper_write) else $error("selection write lost");

endmodule : pbm_pin_mux

/* File: verif/pbm_periph_model.sv */
module pbm_periph_model (
  input  wire logic [15:0] i_vec,
  input  wire logic [15:0] i_pb_oe,
  input  wire logic [15:0] i_pb_out,
  output logic      [15:0] o_pb_lvl,
  output logic      [15:0] o_pattern
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // pins and pattern source
  // ------------------------------------------------------------
  assign o_pattern = i_vec;
  // wire level seen
  // outside device drives the inverse of vec, so a released pin never reads as a stale value
  assign o_pb_lvl = (i_pb_oe & i_pb_out) | (~i_pb_oe & ~i_vec);
endmodule : pbm_periph_model

/* File: verif/tb_port_b_and_cas_pin_function_select.sv */
module tb_port_b_and_cas_pin_function_select;
  timeunit 1ns;
  timeprecision 1ns;
  import pbm_pkg::*;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [15:0] vec, lvl, pat, pb_pin, pb_oe, eo, ep, el;
  logic [3:0]  irq;
  logic [5:0]  capin;
  logic        s1ck, s0ck, rx1, rx0, tcd, tcc, sh_pin, sh_oe, sl_pin, sl_oe, er;
  logic [1:0]  c, h, l;
  int          err_count, compares;

  // ------------------------------------------------------------
  // design and far side
  // ------------------------------------------------------------
  pbm_pin_mux dut_u (
    .i_sys_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_pb_pin(lvl), .o_pb_pin(pb_pin), .o_pb_oe(pb_oe), .i_pattern_output(pat),
    .o_interrupt_input_seven(irq[3]), .o_interrupt_input_six(irq[2]),
    .o_interrupt_input_five(irq[1]), .o_interrupt_input_four(irq[0]),
    .i_serial_ch1_clock_out(vec[0]), .i_serial_ch1_clock_oe(vec[1]), .o_serial_ch1_clock_in(s1ck),
    .i_serial_ch0_clock_out(vec[2]), .i_serial_ch0_clock_oe(vec[3]), .o_serial_ch0_clock_in(s0ck),
    .i_serial_ch1_transmit(vec[4]), .i_serial_ch0_transmit(vec[5]),
    .o_serial_ch1_receive(rx1), .o_serial_ch0_receive(rx0),
    .o_timer_clock_input_d(tcd), .o_timer_clock_input_c(tcc),
    .i_timer4_compare_out_b(vec[6]), .i_timer4_compare_out_a(vec[7]),
    .i_timer_capcomp_out(vec[11:6]), .i_timer_capcomp_oe(vec[15:10]), .o_timer_capcomp_in(capin),
    .i_chip_select_one(vec[8]), .i_chip_select_three(vec[9]),
    .i_column_strobe_high(vec[12]), .i_column_strobe_low(vec[13]),
    .o_strobe_high_pin(sh_pin), .o_strobe_high_oe(sh_oe),
    .o_strobe_low_pin(sl_pin), .o_strobe_low_oe(sl_oe)
  );
  pbm_periph_model far_u (.i_vec(vec), .i_pb_oe(pb_oe), .i_pb_out(pb_pin), .o_pb_lvl(lvl), .o_pattern(pat));

  // ------------------------------------------------------------
  // clock, tasks
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [31:0] idx, input logic [31:0] wd);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {idx[29:0], 2'b00};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // no wait limit here: a hang is ended by the watchdog
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rdchk(input logic [31:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
    chk(32'(er), 32'h0);
  endtask : rdchk

  task automatic summarize();
    $display("mismatches %0d of %0d compares", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  initial begin
    #200us;
    err_count++;
    summarize();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    err_count = 0;
    compares  = 0;
    rst = 1'b1;
    {psel, penable, pwrite} = 3'b000;
    paddr  = 32'h0;
    pwdata = 32'h0;
    vec    = 16'h3ca5;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdchk(PBM_IDX_UPPER, 32'h0);
    rdchk(PBM_IDX_LOWER, 32'h0);
    rdchk(PBM_IDX_DIR, 32'h0);
    rdchk(PBM_IDX_STROBE, 32'h5fff);
    chk(32'(pb_oe), 32'h0);
    apb(1'b0, 32'h0, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    // every code on every line, two source patterns
    for (int k = 0; k < 8; k++) begin
      c   = k[1:0];
      vec <= k[2] ? 16'hc35a : 16'h3ca5;
      apb(1'b1, PBM_IDX_UPPER, {16'h0, {8{c}}});
      apb(1'b1, PBM_IDX_LOWER, {16'h0, {8{c}}});
      repeat (3) @(posedge clk);
      case (c)
        2'h2: eo = {2'b00, vec[1], vec[3], 4'b1010, 2'b11, vec[15:10]};
        2'h3: eo = 16'hffff;
        default: eo = 16'h0;
      endcase
      ep = (c == 2'h3) ? vec : {2'b00, vec[0], vec[2], vec[4], 1'b0, vec[5], 1'b0, vec[6], vec[7], vec[11:6]};
      el = (eo & ep) | (~eo & ~vec);
      chk(32'(pb_oe), 32'(eo));
      chk(32'(pb_pin & pb_oe), 32'(ep & eo));
      chk(32'({irq, tcd, tcc}), (c == 2'h1) ? 32'({el[15:12], el[7:6]}) : 32'h0);
      chk(32'({rx1, rx0, capin, s1ck, s0ck}),
          (c == 2'h2) ? 32'({el[10], el[8], el[5:0], el[13:12]}) : 32'h0);
    end
    apb(1'b1, PBM_IDX_UPPER, 32'h0);
    apb(1'b1, PBM_IDX_LOWER, 32'h0);
    apb(1'b1, PBM_IDX_DIR, 32'hffff);
    apb(1'b1, PBM_IDX_DATA, 32'h1234);
    repeat (3) @(posedge clk);
    chk({pb_oe, pb_pin}, 32'hffff1234);
    rdchk(PBM_IDX_DATA, 32'h1234);
    apb(1'b1, PBM_IDX_DIR, 32'h0);
    repeat (3) @(posedge clk);
    chk(32'(pb_oe), 32'h0);
    rdchk(PBM_IDX_DATA, {16'h0, ~vec});
    // strobe pins: each code once on each pin, low code the complement of high, fixed bits read as ones
    for (int k = 0; k < 4; k++) begin
      h = k[1:0];
      l = 2'(3 - k);
      apb(1'b1, PBM_IDX_STROBE, {16'h0, h, l, 12'h000});
      rdchk(PBM_IDX_STROBE, {16'h0, h, l, 12'hfff});
      repeat (3) @(posedge clk);
      chk(32'({sh_oe, sl_oe}), 32'({h == 2'h1 || h == 2'h2, l == 2'h1 || l == 2'h2}));
      chk(32'({sh_pin & sh_oe, sl_pin & sl_oe}),
          32'({(h == 2'h1 && vec[8]) || (h == 2'h2 && vec[12]),
               (l == 2'h1 && vec[9]) || (l == 2'h2 && vec[13])}));
    end
    summarize();
  end
endmodule : tb_port_b_and_cas_pin_function_select
